// ---- verif/clock_power_checker.sv ----
// Checker bound to the clock and power management block ports.
`timescale 1ns/10ps
module clock_power_checker (
  input wire        CLK,
  input wire        RST_N,
  input wire        AWREADY,
  input wire        BVALID,
  input wire        BREADY,
  input wire [1:0]  BRESP,
  input wire        ARREADY,
  input wire        RVALID,
  input wire        RREADY,
  input wire [31:0] RDATA,
  input wire [2:0]  CLOCK_OPTION,
  input wire        CPU_CLK_EN,
  input wire        FETCH_EN,
  input wire        PERIPH_RUN,
  input wire        OSC_RUN,
  input wire        RTC_TICK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Stop ends when the oscillator restarts.
  sequence stop_wake_s;
    $rose(OSC_RUN);
  endsequence
  sequence warm_gate_s;
    !CPU_CLK_EN [*8];
  endsequence
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  read_busy_a: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while busy");
  write_busy_a: assert property (BVALID |-> !AWREADY)
    else $error("write address taken while busy");
  fetch_cpu_a: assert property (FETCH_EN |-> CPU_CLK_EN)
    else $error("fetch pulse without cpu pulse");
  run_needs_a: assert property (CPU_CLK_EN |-> PERIPH_RUN && OSC_RUN)
    else $error("cpu clock while suspended");
  stop_quiet_a: assert property (!OSC_RUN |-> !PERIPH_RUN && !CPU_CLK_EN)
    else $error("activity in stop");
  stop_warm_a: assert property (stop_wake_s |-> warm_gate_s)
    else $error("cpu clock before warm-up");
  rtc_option_a: assert property (RTC_TICK |-> CLOCK_OPTION == 3'h1)
    else $error("rtc tick in wrong option");
endmodule
bind system_clock_power_mgmt clock_power_checker i_clock_power_checker (
  .CLK(CLK), .RST_N(RST_N), .AWREADY(AWREADY), .BVALID(BVALID),
  .BREADY(BREADY), .BRESP(BRESP), .ARREADY(ARREADY), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .CLOCK_OPTION(CLOCK_OPTION),
  .CPU_CLK_EN(CPU_CLK_EN), .FETCH_EN(FETCH_EN), .PERIPH_RUN(PERIPH_RUN),
  .OSC_RUN(OSC_RUN), .RTC_TICK(RTC_TICK));

// ---- verif/testbench.sv ----
// Self-checking bench for the clock and power management block.
`timescale 1ns/10ps
`include "clock_power_consts.vh"
module testbench;
  reg         CLK = 1'b0;
  reg         RST_N = 1'b0;
  reg  [7:0]  AWADDR = 8'h00;
  reg  [7:0]  ARADDR = 8'h00;
  reg  [31:0] WDATA = 32'h0;
  reg  [3:0]  WSTRB = 4'hf;
  reg         AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  reg         ARVALID = 1'b0, RREADY = 1'b0;
  reg  [2:0]  CLOCK_OPTION = `OPT_INTERNAL_FAST_RC;
  reg  [3:0]  slow_q = 4'h0;
  reg  [7:0]  WAKE_PORT_A = 8'h00;
  reg  [7:0]  WAKE_PORT_B = 8'h00;
  reg         IRQ_EVENT = 1'b0;
  reg         gp_dout = 1'b0, gp_doe = 1'b0, pin_ext = 1'b1;
  wire        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire [1:0]  BRESP, RRESP;
  wire [31:0] RDATA;
  wire        CPU_CLK_EN, FETCH_EN, PERIPH_RUN, OSC_RUN, RTC_TICK;
  wire [7:0]  XRAM_WAIT_CTRL;
  wire        in_o, in_oe, out_o, out_oe, in_din, out_din;
  wire        in_pin  = in_oe ? in_o : pin_ext;
  wire        out_pin = out_oe ? out_o : pin_ext;
  integer     n_errors = 0, check_count = 0, i, c, f, r;
  reg  [31:0] v;
  always #10 CLK = ~CLK;
  always @(posedge CLK) slow_q <= slow_q + 4'h1;
  system_clock_power_mgmt #(.CFG_FAST_CYCLES(18'h00010))
    i_system_clock_power_mgmt (
    .CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CLOCK_OPTION(CLOCK_OPTION), .INTERNAL_SLOW_RC(slow_q[1]),
    .WAKE_PORT_A(WAKE_PORT_A), .WAKE_PORT_B(WAKE_PORT_B),
    .IRQ_EVENT(IRQ_EVENT), .CPU_CLK_EN(CPU_CLK_EN), .FETCH_EN(FETCH_EN),
    .PERIPH_RUN(PERIPH_RUN), .OSC_RUN(OSC_RUN),
    .XRAM_WAIT_CTRL(XRAM_WAIT_CTRL), .RTC_TICK(RTC_TICK),
    .OSC_INPUT_PIN_I(in_pin), .OSC_INPUT_PIN_O(in_o),
    .OSC_INPUT_PIN_OE(in_oe), .OSC_OUTPUT_PIN_I(out_pin),
    .OSC_OUTPUT_PIN_O(out_o), .OSC_OUTPUT_PIN_OE(out_oe),
    .GPIO_IN_PIN_DOUT(gp_dout), .GPIO_IN_PIN_DOE(gp_doe),
    .GPIO_IN_PIN_DIN(in_din), .GPIO_OUT_PIN_DOUT(gp_dout),
    .GPIO_OUT_PIN_DOE(gp_doe), .GPIO_OUT_PIN_DIN(out_din));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, tb;
    begin
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      tb = 1'b0;
      while (!tb)
      begin
        @(negedge CLK);
        ta = AWVALID && AWREADY;
        tw = WVALID && WREADY;
        tb = BVALID;
        v = {30'h0, BRESP};
        @(posedge CLK);
        if (ta) AWVALID <= 1'b0;
        if (tw) WVALID <= 1'b0;
      end
      BREADY <= 1'b0;
      chk("bresp", er, v);
    end
  endtask
  task rd(input [7:0] a, input [1:0] er);
    reg ta, tr;
    begin
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      tr = 1'b0;
      while (!tr)
      begin
        @(negedge CLK);
        ta = ARVALID && ARREADY;
        tr = RVALID;
        if (tr) chk("rresp", er, RRESP);
        v = RDATA;
        @(posedge CLK);
        if (ta) ARVALID <= 1'b0;
      end
      RREADY <= 1'b0;
    end
  endtask
  // Counts cpu and fetch pulses over n cycles, ending on a rising edge.
  task cnt(input integer n);
    begin
      c = 0;
      f = 0;
      r = 0;
      repeat (n)
      begin
        @(negedge CLK);
        c = c + CPU_CLK_EN;
        f = f + FETCH_EN;
        r = r + RTC_TICK;
      end
      @(posedge CLK);
    end
  endtask
  task pulse_irq;
    begin
      IRQ_EVENT <= 1'b1;
      @(posedge CLK);
      IRQ_EVENT <= 1'b0;
    end
  endtask
  // Resets the block and waits for the first cpu pulse after warm-up.
  task boot;
    begin
      RST_N <= 1'b0;
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      i = 0;
      while (CPU_CLK_EN !== 1'b1 && i < 4000)
      begin
        @(negedge CLK);
        i = i + 1;
      end
      @(posedge CLK);
      chk("boot_len", 1, i > 2100 && i < 2140);
    end
  endtask
  task give_verdict;
    begin
      if (n_errors == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    #(20 * 30000);
    n_errors = n_errors + 1;
    give_verdict;
  end
  initial
  begin
    boot;
    rd(`OFF_CPU_DIVIDER_SELECT, `RESP_OKAY);
    chk("sel_rst", 32'h7, v);
    rd(`OFF_FETCH_STRETCH_CTRL, `RESP_OKAY);
    chk("fetch_rst", 32'h71, v);
    rd(`OFF_CLOCK_APPLY_CMD, `RESP_OKAY);
    chk("cmd_rst", 0, v);
    rd(`OFF_POWER_CONTROL_REG, `RESP_OKAY);
    chk("power_control_reg_rst", 32'h08, v);
    rd(8'h14, `RESP_SLVERR);
    chk("unmapped", 0, v);
    wr(`OFF_STATUS, 0, `RESP_SLVERR);
    cnt(256);
    chk("fetch7", 32, f);
    wr(`OFF_FETCH_STRETCH_CTRL, 32'h35, `RESP_OKAY);
    cnt(16);
    cnt(256);
    chk("fetch3", 64, f);
    chk("xram", 32'h05, XRAM_WAIT_CTRL);
    wr(`OFF_FETCH_STRETCH_CTRL, 32'h70, `RESP_OKAY);
    wr(`OFF_CPU_DIVIDER_SELECT, 5, `RESP_OKAY);
    wr(`OFF_CLOCK_APPLY_CMD, 32'h68, `RESP_OKAY);
    cnt(256);
    chk("no_apply", 256, c);
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(`OFF_CPU_DIVIDER_SELECT, i, `RESP_OKAY);
      wr(`OFF_CLOCK_APPLY_CMD, `CLOCK_APPLY_KEY, `RESP_OKAY);
      cnt(128);
      cnt(256);
      chk("cpu_rate", 256 >> (7 - i), c);
    end
    wr(`OFF_CPU_DIVIDER_SELECT, 5, `RESP_OKAY);
    wr(`OFF_CLOCK_APPLY_CMD, `CLOCK_APPLY_KEY, `RESP_OKAY);
    wr(`OFF_FETCH_STRETCH_CTRL, 32'h00, `RESP_OKAY);
    wr(`OFF_POWER_CONTROL_REG, 32'h09, `RESP_OKAY);
    cnt(4);
    cnt(64);
    chk("idle_cpu", 0, c);
    chk("idle_run", 3, {PERIPH_RUN, OSC_RUN});
    WAKE_PORT_A <= 8'h01;
    cnt(8);
    rd(`OFF_POWER_CONTROL_REG, `RESP_OKAY);
    chk("idle_port", 32'h08, v);
    cnt(128);
    cnt(256);
    chk("resume", 64, c);
    wr(`OFF_POWER_CONTROL_REG, 32'h09, `RESP_OKAY);
    cnt(4);
    cnt(64);
    chk("idle_cpu2", 0, c);
    pulse_irq;
    cnt(8);
    rd(`OFF_POWER_CONTROL_REG, `RESP_OKAY);
    chk("idle_irq", 32'h08, v);
    wr(`OFF_POWER_CONTROL_REG, 32'h0a, `RESP_OKAY);
    cnt(4);
    chk("stop_run", 0, {PERIPH_RUN, OSC_RUN});
    pulse_irq;
    cnt(100);
    chk("stop_irq", 0, c + OSC_RUN);
    WAKE_PORT_B <= 8'h80;
    cnt(64);
    chk("warm_gate", 0, c);
    cnt(200);
    rd(`OFF_POWER_CONTROL_REG, `RESP_OKAY);
    chk("stop_clear", 32'h08, v);
    rd(`OFF_CPU_DIVIDER_SELECT, `RESP_OKAY);
    chk("kept_sel", 32'h5, v);
    cnt(256);
    chk("stop_resume", 64, c);
    gp_doe <= 1'b1;
    gp_dout <= 1'b1;
    cnt(8);
    chk("pin_oe", 3, {in_oe, out_oe});
    chk("pin_lvl", 3, {in_din, out_din});
    gp_doe <= 1'b0;
    pin_ext <= 1'b0;
    cnt(8);
    chk("pin_rel", 0, {in_oe, in_din});
    CLOCK_OPTION <= `OPT_INTERNAL_FAST_RC_RTC;
    boot;
    chk("rtc_pins", 2, {out_oe, in_oe});
    pin_ext <= 1'b1;
    cnt(8);
    chk("rtc_tick", 1, r);
    chk("rtc_drive", 0, out_din);
    CLOCK_OPTION <= `OPT_XTAL_HIGH;
    cnt(8);
    rd(`OFF_STATUS, `RESP_OKAY);
    chk("opt_fixed", 32'h57, v);
    boot;
    wr(`OFF_POWER_CONTROL_REG, 32'h0a, `RESP_OKAY);
    cnt(4);
    chk("xtal_stop", 0, out_oe);
    WAKE_PORT_A <= 8'h00;
    cnt(2000);
    chk("xtal_warm", 0, c);
    cnt(200);
    chk("xtal_run", 1, c > 50);
    wr(`OFF_CPU_DIVIDER_SELECT, 6, `RESP_OKAY);
    wr(`OFF_CLOCK_APPLY_CMD, `CLOCK_APPLY_KEY, `RESP_OKAY);
    cnt(128);
    cnt(256);
    chk("cpu_rate", 128, c);
    CLOCK_OPTION <= `OPT_XTAL_LOW;
    boot;
    wr(`OFF_CPU_DIVIDER_SELECT, 7, `RESP_OKAY);
    wr(`OFF_CLOCK_APPLY_CMD, `CLOCK_APPLY_KEY, `RESP_OKAY);
    cnt(256);
    chk("cpu_rate", 256, c);
    chk("fetch_boot", 32, f);
    give_verdict;
  end
endmodule

// ---- verilog/clock_power_consts.vh ----
// Constants for the system clock and power management block.
`ifndef CLOCK_POWER_CONSTS_VH
`define CLOCK_POWER_CONSTS_VH
`define OFF_CPU_DIVIDER_SELECT  8'h00
`define OFF_FETCH_STRETCH_CTRL  8'h04
`define OFF_CLOCK_APPLY_CMD     8'h08
`define OFF_POWER_CONTROL_REG   8'h0c
`define OFF_STATUS              8'h10
`define RST_CPU_DIVIDER_SELECT  3'h7
`define RST_FETCH_STRETCH_CTRL  8'h71
`define RST_POWER_CONTROL_REG   8'h08
`define CLOCK_APPLY_KEY         8'h69
`define POWER_CONTROL_REG_IDLE_BIT           0
`define POWER_CONTROL_REG_STOP_BIT           1
`define FETCH_LO                4
`define FETCH_HI                6
`define CFG_SLOW_PERIODS        4'h8
`define WARM_SLOW_PERIODS       4'h5
`define WARM_FAST_XTAL          18'h00800
`define WARM_FAST_RC            18'h00040
`define OPT_INTERNAL_FAST_RC                3'h0
`define OPT_INTERNAL_FAST_RC_RTC            3'h1
`define OPT_XTAL_HIGH           3'h2
`define OPT_XTAL_LOW            3'h3
`define OPT_EXT_CLOCK           3'h4
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2
`endif

// ---- verilog/system_clock_power_mgmt.v ----
// CPU clock divider, fetch stretch, idle and stop control with warm-up.
`timescale 1ns/10ps
`include "clock_power_consts.vh"
module system_clock_power_mgmt #(
  parameter [17:0] CFG_FAST_CYCLES = 18'h20000
)(
  input  wire        CLK,
  input  wire        RST_N,
  input  wire [7:0]  AWADDR,
  input  wire        AWVALID,
  output reg         AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output reg         WREADY,
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  input  wire [7:0]  ARADDR,
  input  wire        ARVALID,
  output reg         ARREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY,
  input  wire [2:0]  CLOCK_OPTION,
  input  wire        INTERNAL_SLOW_RC,
  input  wire [7:0]  WAKE_PORT_A,
  input  wire [7:0]  WAKE_PORT_B,
  input  wire        IRQ_EVENT,
  output reg         CPU_CLK_EN,
  output reg         FETCH_EN,
  output reg         PERIPH_RUN,
  output reg         OSC_RUN,
  output reg  [7:0]  XRAM_WAIT_CTRL,
  output reg         RTC_TICK,
  input  wire        OSC_INPUT_PIN_I,
  output reg         OSC_INPUT_PIN_O,
  output reg         OSC_INPUT_PIN_OE,
  input  wire        OSC_OUTPUT_PIN_I,
  output reg         OSC_OUTPUT_PIN_O,
  output reg         OSC_OUTPUT_PIN_OE,
  input  wire        GPIO_IN_PIN_DOUT,
  input  wire        GPIO_IN_PIN_DOE,
  output reg         GPIO_IN_PIN_DIN,
  input  wire        GPIO_OUT_PIN_DOUT,
  input  wire        GPIO_OUT_PIN_DOE,
  output reg         GPIO_OUT_PIN_DIN
);
  localparam ST_CFG  = 3'h0;
  localparam ST_WARM = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_IDLE = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam [17:0] CFG_LAST = CFG_FAST_CYCLES - 18'h00001;

  reg  [2:0]  st_q;
  reg  [17:0] fast_q;
  reg  [3:0]  slow_q;
  reg  [17:0] warm_len_q;
  reg  [2:0]  opt_q;
  reg  [2:0]  opt_s1_q;
  reg  [2:0]  opt_s2_q;
  reg  [7:0]  pa_s1_q;
  reg  [7:0]  pa_s2_q;
  reg  [7:0]  pa_p_q;
  reg  [7:0]  pb_s1_q;
  reg  [7:0]  pb_s2_q;
  reg  [7:0]  pb_p_q;
  reg         slow_s1_q;
  reg         slow_s2_q;
  reg         slow_p_q;
  reg         xin_s1_q;
  reg         xin_s2_q;
  reg         xin_p_q;
  reg         osc_output_pin_s1_q;
  reg         osc_output_pin_s2_q;
  reg  [2:0]  div_sel_q;
  reg  [2:0]  div_app_q;
  reg  [7:0]  fetch_ctl_q;
  reg  [7:0]  power_control_reg_q;
  reg  [6:0]  div_q;
  reg  [2:0]  fetch_cnt_q;
  reg         aw_full_q;
  reg         w_full_q;
  reg  [7:0]  aw_addr_q;
  reg  [7:0]  w_data_q;
  reg         w_lane0_q;
  reg  [31:0] rd_data;
  reg         rd_ok;

  wire        slow_tick = slow_s2_q & ~slow_p_q;
  wire        port_chg  = |((pa_s2_q ^ pa_p_q) | (pb_s2_q ^ pb_p_q));
  wire        wake_idle = (st_q == ST_IDLE) & (port_chg | IRQ_EVENT);
  wire        wake_stop = (st_q == ST_STOP) & port_chg;
  wire [6:0]  div_mask  = 7'h7f >> div_app_q;
  wire        cpu_tick  = (div_q & div_mask) == div_mask;
  wire        do_write  = aw_full_q & w_full_q & ~BVALID;
  wire        wr_lane   = do_write & w_lane0_q;
  wire        rc_source = (opt_q == `OPT_INTERNAL_FAST_RC) | (opt_q == `OPT_INTERNAL_FAST_RC_RTC);
  wire        xtal_drv  = (opt_q == `OPT_XTAL_HIGH) | (opt_q == `OPT_XTAL_LOW);

  // Pin inputs pass two flip-flops before any logic looks at them.
  always @(posedge CLK)
  begin
    opt_s1_q  <= CLOCK_OPTION;
    opt_s2_q  <= opt_s1_q;
    pa_s1_q   <= WAKE_PORT_A;
    pa_s2_q   <= pa_s1_q;
    pa_p_q    <= pa_s2_q;
    pb_s1_q   <= WAKE_PORT_B;
    pb_s2_q   <= pb_s1_q;
    pb_p_q    <= pb_s2_q;
    slow_s1_q <= INTERNAL_SLOW_RC;
    slow_s2_q <= slow_s1_q;
    slow_p_q  <= slow_s2_q;
    xin_s1_q  <= OSC_INPUT_PIN_I;
    xin_s2_q  <= xin_s1_q;
    xin_p_q   <= xin_s2_q;
    osc_output_pin_s1_q <= OSC_OUTPUT_PIN_I;
    osc_output_pin_s2_q <= osc_output_pin_s1_q;
  end

  // Power sequencing: configuration, warm-up, run, idle and stop.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st_q       <= ST_CFG;
      fast_q     <= 18'h00000;
      slow_q     <= 4'h0;
      warm_len_q <= `WARM_FAST_XTAL;
      opt_q      <= `OPT_INTERNAL_FAST_RC;
    end
    else
    begin
      case (st_q)
        ST_CFG:
        begin
          if (slow_q != `CFG_SLOW_PERIODS)
          begin
            if (slow_tick)
              slow_q <= slow_q + 4'h1;
          end
          else if (fast_q != CFG_LAST)
            fast_q <= fast_q + 18'h00001;
          else
          begin
            st_q       <= ST_WARM;
            fast_q     <= 18'h00000;
            slow_q     <= 4'h0;
            opt_q      <= opt_s2_q;
            warm_len_q <= `WARM_FAST_XTAL;
          end
        end
        ST_WARM:
        begin
          if (fast_q != warm_len_q - 18'h00001)
            fast_q <= fast_q + 18'h00001;
          else if (slow_q != `WARM_SLOW_PERIODS)
          begin
            if (slow_tick)
              slow_q <= slow_q + 4'h1;
          end
          else
          begin
            st_q   <= ST_RUN;
            fast_q <= 18'h00000;
            slow_q <= 4'h0;
          end
        end
        ST_RUN:
        begin
          if (power_control_reg_q[`POWER_CONTROL_REG_STOP_BIT])
            st_q <= ST_STOP;
          else if (power_control_reg_q[`POWER_CONTROL_REG_IDLE_BIT])
            st_q <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (wake_idle)
            st_q <= ST_RUN;
        end
        ST_STOP:
        begin
          if (wake_stop)
          begin
            st_q       <= ST_WARM;
            warm_len_q <= rc_source ? `WARM_FAST_RC
                                    : `WARM_FAST_XTAL;
          end
        end
        default:
          st_q <= ST_CFG;
      endcase
    end
  end

  // Source divider and fetch stretch; both hold their count in stop.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      div_q       <= 7'h00;
      fetch_cnt_q <= 3'h0;
      CPU_CLK_EN  <= 1'b0;
      FETCH_EN    <= 1'b0;
      PERIPH_RUN  <= 1'b0;
      OSC_RUN     <= 1'b1;
    end
    else
    begin
      if (st_q != ST_STOP)
        div_q <= div_q + 7'h01;
      CPU_CLK_EN <= (st_q == ST_RUN) & cpu_tick;
      FETCH_EN   <= (st_q == ST_RUN) & cpu_tick &
                    (fetch_cnt_q == fetch_ctl_q[`FETCH_HI:`FETCH_LO]);
      if ((st_q == ST_RUN) & cpu_tick)
      begin
        if (fetch_cnt_q == fetch_ctl_q[`FETCH_HI:`FETCH_LO])
          fetch_cnt_q <= 3'h0;
        else
          fetch_cnt_q <= fetch_cnt_q + 3'h1;
      end
      PERIPH_RUN <= (st_q == ST_RUN) | (st_q == ST_IDLE);
      OSC_RUN    <= (st_q != ST_STOP);
    end
  end

  // Oscillator pins follow the source option loaded at power-on.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      OSC_INPUT_PIN_O   <= 1'b0;
      OSC_INPUT_PIN_OE  <= 1'b0;
      OSC_OUTPUT_PIN_O  <= 1'b0;
      OSC_OUTPUT_PIN_OE <= 1'b0;
      GPIO_IN_PIN_DIN   <= 1'b0;
      GPIO_OUT_PIN_DIN  <= 1'b0;
      RTC_TICK          <= 1'b0;
    end
    else
    begin
      GPIO_IN_PIN_DIN  <= xin_s2_q;
      GPIO_OUT_PIN_DIN <= osc_output_pin_s2_q;
      RTC_TICK <= (st_q != ST_CFG) & (opt_q == `OPT_INTERNAL_FAST_RC_RTC) &
                  xin_s2_q & ~xin_p_q;
      OSC_INPUT_PIN_O   <= 1'b0;
      OSC_INPUT_PIN_OE  <= 1'b0;
      OSC_OUTPUT_PIN_O  <= 1'b0;
      OSC_OUTPUT_PIN_OE <= 1'b0;
      if (st_q != ST_CFG)
      begin
        if (opt_q == `OPT_INTERNAL_FAST_RC)
        begin
          OSC_INPUT_PIN_O  <= GPIO_IN_PIN_DOUT;
          OSC_INPUT_PIN_OE <= GPIO_IN_PIN_DOE;
        end
        if ((opt_q == `OPT_INTERNAL_FAST_RC) | (opt_q == `OPT_EXT_CLOCK))
        begin
          OSC_OUTPUT_PIN_O  <= GPIO_OUT_PIN_DOUT;
          OSC_OUTPUT_PIN_OE <= GPIO_OUT_PIN_DOE;
        end
        if ((opt_q == `OPT_INTERNAL_FAST_RC_RTC) | (xtal_drv & (st_q != ST_STOP)))
        begin
          OSC_OUTPUT_PIN_O  <= ~xin_s2_q;
          OSC_OUTPUT_PIN_OE <= 1'b1;
        end
      end
    end
  end

  // Register file; a software write of a request wins over a wake clear.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      div_sel_q      <= `RST_CPU_DIVIDER_SELECT;
      div_app_q      <= `RST_CPU_DIVIDER_SELECT;
      fetch_ctl_q    <= `RST_FETCH_STRETCH_CTRL;
      power_control_reg_q         <= `RST_POWER_CONTROL_REG;
      XRAM_WAIT_CTRL <= 8'h00;
    end
    else
    begin
      XRAM_WAIT_CTRL <= {4'h0, fetch_ctl_q[3:0]};
      if (wake_idle)
        power_control_reg_q[`POWER_CONTROL_REG_IDLE_BIT] <= 1'b0;
      if (wake_stop)
        power_control_reg_q[`POWER_CONTROL_REG_STOP_BIT] <= 1'b0;
      if (wr_lane & (aw_addr_q == `OFF_CPU_DIVIDER_SELECT))
        div_sel_q <= w_data_q[2:0];
      if (wr_lane & (aw_addr_q == `OFF_CLOCK_APPLY_CMD) &
          (w_data_q == `CLOCK_APPLY_KEY))
        div_app_q <= div_sel_q;
      if (wr_lane & (aw_addr_q == `OFF_FETCH_STRETCH_CTRL))
        fetch_ctl_q <= {1'b0, w_data_q[6:0]};
      if (wr_lane & (aw_addr_q == `OFF_POWER_CONTROL_REG))
        power_control_reg_q <= {w_data_q[7], 3'h0, w_data_q[3:0]};
    end
  end

  // Read decode.
  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (ARADDR == `OFF_CPU_DIVIDER_SELECT)
      rd_data = {29'h0, div_sel_q};
    else if (ARADDR == `OFF_FETCH_STRETCH_CTRL)
      rd_data = {24'h0, fetch_ctl_q};
    else if (ARADDR == `OFF_CLOCK_APPLY_CMD)
      rd_data = 32'h00000000;
    else if (ARADDR == `OFF_POWER_CONTROL_REG)
      rd_data = {24'h0, power_control_reg_q};
    else if (ARADDR == `OFF_STATUS)
      rd_data = {23'h0, opt_q, st_q, div_app_q};
    else
      rd_ok = 1'b0;
  end

  // AXI4-Lite slave: address and data taken in either order.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= `RESP_OKAY;
      ARREADY   <= 1'b0;
      RVALID    <= 1'b0;
      RRESP     <= `RESP_OKAY;
      RDATA     <= 32'h00000000;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else
    begin
      AWREADY <= ~aw_full_q & ~(AWVALID & AWREADY);
      WREADY  <= ~w_full_q & ~(WVALID & WREADY);
      if (AWVALID & AWREADY)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end
      if (WVALID & WREADY)
      begin
        w_full_q  <= 1'b1;
        w_data_q  <= WDATA[7:0];
        w_lane0_q <= WSTRB[0];
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= ((aw_addr_q <= `OFF_STATUS) & (aw_addr_q[1:0] == 2'h0)
                      & (aw_addr_q != `OFF_STATUS)) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
      end
      else if (BVALID & BREADY)
        BVALID <= 1'b0;
      ARREADY <= ~RVALID & ~(ARVALID & ARREADY);
      if (ARVALID & ARREADY)
      begin
        RVALID <= 1'b1;
        RDATA  <= rd_data;
        RRESP  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (RVALID & RREADY)
        RVALID <= 1'b0;
    end
  end
endmodule
